// file: design/pcoc_regs.svh
`ifndef PCOC_REGS_SVH
`define PCOC_REGS_SVH

// Register offsets, word addresses on the plain register port.
`define PCOC_ADDR_RATIO0 4'h0
`define PCOC_ADDR_RATIO1 4'h1
`define PCOC_ADDR_RATIO2 4'h2
`define PCOC_ADDR_RATIO3 4'h3
`define PCOC_ADDR_MODAL 4'h4
`define PCOC_ADDR_GLOBAL 4'h5
`define PCOC_ADDR_STATUS 4'h6
`define PCOC_ADDR_EFF_RATIO 4'h7
`define PCOC_ADDR_EFF_MODE 4'h8

// Modal register: one 5-bit field per set, set n at bits 5n+4..5n.
`define PCOC_MODAL_FIELD_W 5
`define PCOC_MODAL_SHIFT_LSB 0
`define PCOC_MODAL_AUX_LSB 2
`define PCOC_MODAL_AUTO_BIT 4

// Global register fields.
`define PCOC_GLB_SKIP_BIT 0
`define PCOC_GLB_LOCKSTYLE_BIT 1
`define PCOC_GLB_REFDIV_LSB 2
`define PCOC_GLB_UNLOCK_BIT 4
`define PCOC_GLB_FORMAT_BIT 5
`define PCOC_GLB_PINFUNC_LSB 6
`define PCOC_GLB_BW_LSB 9

// Reset values.
`define PCOC_RATIO_RST 32'h0000_1000
`define PCOC_MODAL_RST 20'h00000
`define PCOC_GLOBAL_RST 12'h000

`endif

// file: design/pcoc_pkg.sv
package pcoc_pkg;

  typedef enum logic [1:0] {
    AUX_SRC_REF,
    AUX_SRC_CLKIN,
    AUX_SRC_PLL,
    AUX_SRC_LOCK
  } pcoc_aux_src_t;

  typedef enum logic [2:0] {
    PIN_DIS_MAIN,
    PIN_DIS_AUX,
    PIN_DIS_BOTH,
    PIN_SHIFT_EN,
    PIN_RSVD4,
    PIN_AUTO_OVR,
    PIN_RSVD6,
    PIN_FORCE_PLL
  } pcoc_pin_func_t;

endpackage

// file: design/pcoc_ratio_calc.sv
`timescale 1ns/10ps
`include "pcoc_regs.svh"

// Applies the optional right shift and reports the fixed-point integer part.
module pcoc_ratio_calc (
  // Inputs
  input wire logic [31:0] ratio_i,
  input wire logic [1:0] shift_sel_i,
  input wire logic shift_en_i,
  input wire logic format_i,
  // Outputs
  output logic [31:0] eff_ratio_o,
  output logic [19:0] int_part_o
);

  wire [2:0] shift_amt;
  wire [31:0] shifted;

  assign shift_amt = {1'b0, shift_sel_i} + 3'h1;
  assign shifted = ratio_i >> shift_amt;
  assign eff_ratio_o = shift_en_i ? shifted : ratio_i;
  // 20.12 keeps the top 20 bits as integer, 12.20 only the top 12.
  assign int_part_o = format_i ? {8'h00, eff_ratio_o[31:20]} : eff_ratio_o[31:12];

endmodule // pcoc_ratio_calc

// file: design/pcoc_aux_mux.sv
`timescale 1ns/10ps

// Picks the auxiliary source and shapes the pin when it shows lock state.
module pcoc_aux_mux (
  // Selection
  input wire logic [1:0] src_i,
  input wire logic lock_style_i,
  // Sources
  input wire logic ref_clk_i,
  input wire logic clk_in_i,
  input wire logic pll_clk_i,
  input wire logic locked_i,
  // Pin
  output logic aux_o,
  output logic aux_oe_n_o
);

  wire is_lock;
  wire clk_val;

  assign is_lock = (src_i == pcoc_pkg::AUX_SRC_LOCK);
  assign clk_val = (src_i == pcoc_pkg::AUX_SRC_REF) ? ref_clk_i :
                   (src_i == pcoc_pkg::AUX_SRC_CLKIN) ? clk_in_i : pll_clk_i;
  // Style 0: push-pull, high while unlocked. Style 1: open drain, low or released.
  assign aux_o = !is_lock ? clk_val : (lock_style_i ? 1'b0 : !locked_i);
  assign aux_oe_n_o = is_lock && lock_style_i && locked_i;

endmodule // pcoc_aux_mux

// file: design/pcoc_core.sv
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "pcoc_regs.svh"

module pcoc_core (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  // Register port
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  // Mode pins
  input wire logic [1:0] MODE_SEL_I,
  input wire logic THIRD_MODE_PIN_I,
  // Clock sources and lock state
  input wire logic REF_CLK_I,
  input wire logic CLK_IN_I,
  input wire logic PLL_CLK_I,
  input wire logic PLL_LOCKED_I,
  // Outputs to the synthesizer and pins
  output logic [31:0] EFF_RATIO_O,
  output logic [19:0] RATIO_INT_O,
  output logic RATIO_FORMAT_O,
  output logic AUTO_RATIO_MOD_EN_O,
  output logic SKIP_TOLERANCE_EN_O,
  output logic [2:0] REF_DIVIDE_O,
  output logic [7:0] MIN_LOOP_BW_HZ_O,
  output logic MAIN_CLK_O,
  output logic MAIN_CLK_OE_N_O,
  output logic AUX_O,
  output logic AUX_OE_N_O
);

  logic [31:0] ratio_ff [0:3];
  logic [19:0] modal_ff;
  logic [11:0] global_ff;
  logic [31:0] rdata_ff;
  logic [31:0] eff_ratio_ff;
  logic [19:0] ratio_int_ff;
  logic format_ff;
  logic auto_ff;
  logic skip_ff;
  logic [2:0] ref_div_ff;
  logic [7:0] bw_ff;
  logic main_clk_ff;
  logic main_oe_n_ff;
  logic aux_ff;
  logic aux_oe_n_ff;

  wire [4:0] active_set;
  wire [1:0] ratio_shift_sel;
  wire [1:0] aux_source_sel;
  wire auto_ratio_mod_en;
  wire skip_tolerance_en;
  wire lock_pin_style;
  wire [1:0] ref_divider_sel;
  wire output_during_unlock;
  wire ratio_format_sel;
  wire [2:0] third_pin_function;
  wire [2:0] min_loop_bandwidth;
  wire pin;
  wire shift_en;
  wire auto_en;
  wire [1:0] aux_src;
  wire dis_main;
  wire dis_aux;
  wire unlock_hold;
  wire [31:0] calc_ratio;
  wire [19:0] calc_int;
  wire aux_val;
  wire aux_oe_n;
  wire [2:0] nxt_ref_div;
  wire [7:0] nxt_bw;
  wire [31:0] nxt_rdata;
  wire reg_hit_ratio;

  // Modal set selection by the mode pins.
  assign active_set = modal_ff[{MODE_SEL_I, 2'b00} + {3'b000, MODE_SEL_I} +: 5];
  assign ratio_shift_sel = active_set[`PCOC_MODAL_SHIFT_LSB +: 2];
  assign aux_source_sel = active_set[`PCOC_MODAL_AUX_LSB +: 2];
  assign auto_ratio_mod_en = active_set[`PCOC_MODAL_AUTO_BIT];

  // Global fields come from one register shared by all sets.
  assign skip_tolerance_en = global_ff[`PCOC_GLB_SKIP_BIT];
  assign lock_pin_style = global_ff[`PCOC_GLB_LOCKSTYLE_BIT];
  assign ref_divider_sel = global_ff[`PCOC_GLB_REFDIV_LSB +: 2];
  assign output_during_unlock = global_ff[`PCOC_GLB_UNLOCK_BIT];
  assign ratio_format_sel = global_ff[`PCOC_GLB_FORMAT_BIT];
  assign third_pin_function = global_ff[`PCOC_GLB_PINFUNC_LSB +: 3];
  assign min_loop_bandwidth = global_ff[`PCOC_GLB_BW_LSB +: 3];

  // Third pin decode; reserved codes leave the pin with no effect.
  assign pin = THIRD_MODE_PIN_I;
  assign shift_en = pin && (third_pin_function == pcoc_pkg::PIN_SHIFT_EN);
  assign auto_en = (third_pin_function == pcoc_pkg::PIN_AUTO_OVR) ? pin : auto_ratio_mod_en;
  assign aux_src = (pin && third_pin_function == pcoc_pkg::PIN_FORCE_PLL) ?
                   pcoc_pkg::AUX_SRC_PLL : aux_source_sel;
  assign dis_main = pin && (third_pin_function == pcoc_pkg::PIN_DIS_MAIN ||
                            third_pin_function == pcoc_pkg::PIN_DIS_BOTH);
  assign dis_aux = pin && (third_pin_function == pcoc_pkg::PIN_DIS_AUX ||
                           third_pin_function == pcoc_pkg::PIN_DIS_BOTH);
  assign unlock_hold = !output_during_unlock && !PLL_LOCKED_I;

  // Divider code to divide factor; reserved code gives zero.
  assign nxt_ref_div = (ref_divider_sel == 2'h0) ? 3'h4 :
                       (ref_divider_sel == 2'h1) ? 3'h2 :
                       (ref_divider_sel == 2'h2) ? 3'h1 : 3'h0;
  assign nxt_bw = 8'h01 << min_loop_bandwidth;

  pcoc_ratio_calc u_calc (
    .ratio_i(ratio_ff[MODE_SEL_I]),
    .shift_sel_i(ratio_shift_sel),
    .shift_en_i(shift_en),
    .format_i(ratio_format_sel),
    .eff_ratio_o(calc_ratio),
    .int_part_o(calc_int)
  );

  pcoc_aux_mux u_aux (
    .src_i(aux_src),
    .lock_style_i(lock_pin_style),
    .ref_clk_i(REF_CLK_I),
    .clk_in_i(CLK_IN_I),
    .pll_clk_i(PLL_CLK_I),
    .locked_i(PLL_LOCKED_I),
    .aux_o(aux_val),
    .aux_oe_n_o(aux_oe_n)
  );

  // Read decode.
  assign reg_hit_ratio = (REG_ADDR_I[3:2] == 2'b00);
  assign nxt_rdata = !REG_RD_I ? 32'h0000_0000 :
                     reg_hit_ratio ? ratio_ff[REG_ADDR_I[1:0]] :
                     (REG_ADDR_I == `PCOC_ADDR_MODAL) ? {12'h000, modal_ff} :
                     (REG_ADDR_I == `PCOC_ADDR_GLOBAL) ? {20'h00000, global_ff} :
                     (REG_ADDR_I == `PCOC_ADDR_STATUS) ? {20'h00000, shift_en, auto_en, aux_src,
                                                          dis_main, dis_aux, unlock_hold, PLL_LOCKED_I,
                                                          2'b00, MODE_SEL_I} :
                     (REG_ADDR_I == `PCOC_ADDR_EFF_RATIO) ? eff_ratio_ff :
                     (REG_ADDR_I == `PCOC_ADDR_EFF_MODE) ? {20'h00000, ratio_int_ff[11:0]} :
                     32'h0000_0000;

  // Ratio storage, one word per modal set.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ratio
      always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          ratio_ff[g] <= `PCOC_RATIO_RST;
        end else if (REG_WR_I && reg_hit_ratio && REG_ADDR_I[1:0] == 2'(g)) begin
          ratio_ff[g] <= REG_WDATA_I;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      modal_ff <= `PCOC_MODAL_RST;
      global_ff <= `PCOC_GLOBAL_RST;
    end else if (REG_WR_I && REG_ADDR_I == `PCOC_ADDR_MODAL) begin
      modal_ff <= REG_WDATA_I[19:0];
    end else if (REG_WR_I && REG_ADDR_I == `PCOC_ADDR_GLOBAL) begin
      global_ff <= REG_WDATA_I[11:0];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rdata_ff <= 32'h0000_0000;
      eff_ratio_ff <= 32'h0000_0000;
      ratio_int_ff <= 20'h00000;
      format_ff <= 1'b0;
      auto_ff <= 1'b0;
      skip_ff <= 1'b0;
      ref_div_ff <= 3'h0;
      bw_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
      eff_ratio_ff <= calc_ratio;
      ratio_int_ff <= calc_int;
      format_ff <= ratio_format_sel;
      auto_ff <= auto_en;
      skip_ff <= skip_tolerance_en;
      ref_div_ff <= nxt_ref_div;
      bw_ff <= nxt_bw;
    end
  end

  // Pin stage; clock outputs other than a lock-state aux pin held low while unlocked unless configured otherwise.
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      main_clk_ff <= 1'b0;
      main_oe_n_ff <= 1'b1;
      aux_ff <= 1'b0;
      aux_oe_n_ff <= 1'b1;
    end else begin
      main_clk_ff <= PLL_CLK_I && !unlock_hold;
      main_oe_n_ff <= dis_main;
      aux_ff <= (aux_src == pcoc_pkg::AUX_SRC_LOCK) ? aux_val : (aux_val && !unlock_hold);
      aux_oe_n_ff <= dis_aux || aux_oe_n;
    end
  end

  assign REG_RDATA_O = rdata_ff;
  assign EFF_RATIO_O = eff_ratio_ff;
  assign RATIO_INT_O = ratio_int_ff;
  assign RATIO_FORMAT_O = format_ff;
  assign AUTO_RATIO_MOD_EN_O = auto_ff;
  assign SKIP_TOLERANCE_EN_O = skip_ff;
  assign REF_DIVIDE_O = ref_div_ff;
  assign MIN_LOOP_BW_HZ_O = bw_ff;
  assign MAIN_CLK_O = main_clk_ff;
  assign MAIN_CLK_OE_N_O = main_oe_n_ff;
  assign AUX_O = aux_ff;
  assign AUX_OE_N_O = aux_oe_n_ff;

endmodule // pcoc_core

// file: verif/pcoc_properties.sv
`timescale 1ns/10ps
`include "pcoc_regs.svh"
// Shadows the written configuration and checks decoded outputs one cycle later.
module pcoc_checker (
  // Clock, reset and register writes
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  // Pins
  input wire logic [1:0] MODE_SEL_I,
  input wire logic THIRD_MODE_PIN_I,
  input wire logic PLL_CLK_I,
  input wire logic PLL_LOCKED_I,
  // Outputs
  input wire logic AUTO_RATIO_MOD_EN_O,
  input wire logic SKIP_TOLERANCE_EN_O,
  input wire logic [2:0] REF_DIVIDE_O,
  input wire logic [7:0] MIN_LOOP_BW_HZ_O,
  input wire logic MAIN_CLK_O,
  input wire logic MAIN_CLK_OE_N_O,
  input wire logic AUX_O,
  input wire logic AUX_OE_N_O
);
  logic [11:0] glb_ff;
  logic [19:0] mod_ff;
  logic [1:0] warm_ff;
  wire [4:0] fld = mod_ff[MODE_SEL_I*5 +: 5];
  wire [2:0] fn = glb_ff[8:6];
  wire [2:0] bw = glb_ff[11:9];
  wire p = THIRD_MODE_PIN_I;
  wire dis_main = p && (fn == 3'h0 || fn == 3'h2);
  wire dis_aux = p && (fn == 3'h1 || fn == 3'h2);
  wire fpll = p && fn == 3'h7 && PLL_LOCKED_I;
  wire lsrc = !(p && fn == 3'h7) && fld[3:2] == 2'h3 && !dis_aux;
  wire lpp = lsrc && !glb_ff[1];
  wire lod = lsrc && glb_ff[1];
  wire hold = !PLL_LOCKED_I && !glb_ff[4];
  wire auto_x = (fn == 3'h5) ? p : fld[4];
  wire skip = glb_ff[0];
  wire [2:0] div_x = (glb_ff[3:2] == 2'h3) ? 3'h0 : 3'h4 >> glb_ff[3:2];
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      glb_ff <= `PCOC_GLOBAL_RST;
      mod_ff <= `PCOC_MODAL_RST;
      warm_ff <= 2'h0;
    end else begin
      warm_ff <= {warm_ff[0], 1'b1};
      if (REG_WR_I && REG_ADDR_I == `PCOC_ADDR_GLOBAL) begin
        glb_ff <= REG_WDATA_I[11:0];
      end
      if (REG_WR_I && REG_ADDR_I == `PCOC_ADDR_MODAL) begin
        mod_ff <= REG_WDATA_I[19:0];
      end
    end
  end
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I || !warm_ff[1]);
  bw_decode_a: assert property (MIN_LOOP_BW_HZ_O == 8'h01 << $past(bw))
    else $error("bandwidth decode wrong");
  ref_div_a: assert property (REF_DIVIDE_O == $past(div_x))
    else $error("divider decode wrong");
  skip_flag_a: assert property (SKIP_TOLERANCE_EN_O == $past(skip))
    else $error("skip flag wrong");
  main_off_a: assert property ($past(dis_main) |-> MAIN_CLK_OE_N_O)
    else $error("main output not disabled");
  aux_off_a: assert property ($past(dis_aux) |-> AUX_OE_N_O)
    else $error("aux output not disabled");
  unlock_hold_a: assert property ($past(hold) |-> !MAIN_CLK_O)
    else $error("main clock not held low");
  lock_push_a: assert property ($past(lpp) |-> AUX_O == !$past(PLL_LOCKED_I) && !AUX_OE_N_O)
    else $error("push-pull lock pin wrong");
  lock_drain_a: assert property ($past(lod) |-> !AUX_O && AUX_OE_N_O == $past(PLL_LOCKED_I))
    else $error("open drain lock pin wrong");
  force_pll_a: assert property ($past(fpll) |-> AUX_O == $past(PLL_CLK_I) && !AUX_OE_N_O)
    else $error("aux not forced to pll clock");
  auto_mod_a: assert property (AUTO_RATIO_MOD_EN_O == $past(auto_x))
    else $error("auto modifier enable wrong");
endmodule // pcoc_checker

bind pcoc_core pcoc_checker u_chk (.*);

// file: verif/pcoc_board.sv
`timescale 1ns/10ps
// Board side: mode pins, clock levels and lock state, changed just after an edge.
module pcoc_board (
  // Control from the bench
  input wire logic clk_i,
  input wire logic [6:0] set_i,
  // Pins towards the block
  output logic [1:0] mode_o,
  output logic pin_o,
  output logic ref_o,
  output logic cin_o,
  output logic pll_o,
  output logic lock_o
);
  // Clock sources stand at fixed levels, far below any skip limit.
  always @(posedge clk_i) begin
    {mode_o, pin_o, ref_o, cin_o, pll_o, lock_o} <= set_i;
  end
endmodule // pcoc_board

// file: verif/tb.sv
`timescale 1ns/10ps
`include "pcoc_regs.svh"
module tb;
  localparam logic [31:0] RB = 32'h1234_5678;
  // Row: pin function, pin, main off, aux off, auto enable, aux level, shift applied.
  localparam logic [8:0] ROWS [12] = '{9'b000_1_1_0_1_1_0, 9'b000_0_0_0_1_1_0, 9'b001_1_0_1_1_0_0,
    9'b010_1_1_1_1_0_0, 9'b011_1_0_0_1_1_1, 9'b011_0_0_0_1_1_0, 9'b100_1_0_0_1_1_0, 9'b101_0_0_0_0_1_0,
    9'b101_1_0_0_1_1_0, 9'b110_1_0_0_1_1_0, 9'b111_1_0_0_1_0_0, 9'b111_0_0_0_1_1_0};
  logic CLOCK_I, RESET_N_I, REG_WR_I, REG_RD_I, THIRD_MODE_PIN_I, REF_CLK_I, CLK_IN_I, PLL_CLK_I;
  logic PLL_LOCKED_I, RATIO_FORMAT_O, AUTO_RATIO_MOD_EN_O, SKIP_TOLERANCE_EN_O;
  logic MAIN_CLK_O, MAIN_CLK_OE_N_O, AUX_O, AUX_OE_N_O;
  logic [1:0] MODE_SEL_I;
  logic [2:0] REF_DIVIDE_O;
  logic [3:0] REG_ADDR_I;
  logic [6:0] bset;
  logic [7:0] MIN_LOOP_BW_HZ_O;
  logic [8:0] r;
  logic [19:0] RATIO_INT_O;
  logic [31:0] REG_WDATA_I, REG_RDATA_O, EFF_RATIO_O, e;
  int n_errors = 0;
  int checks_done = 0;
  pcoc_core u_dut (.*);
  pcoc_board u_brd (.clk_i(CLOCK_I), .set_i(bset), .mode_o(MODE_SEL_I), .pin_o(THIRD_MODE_PIN_I),
    .ref_o(REF_CLK_I), .cin_o(CLK_IN_I), .pll_o(PLL_CLK_I), .lock_o(PLL_LOCKED_I));
  task automatic chk(input logic [31:0] seen, input logic [31:0] x);
    checks_done++;
    if (seen !== x) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, x);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= 1'b1;
    @(posedge CLOCK_I);
    REG_WR_I <= 1'b0;
    @(posedge CLOCK_I);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge CLOCK_I);
    REG_RD_I <= 1'b0;
    // Read data stand only in the cycle right after the strobe.
    @(negedge CLOCK_I);
    chk(REG_RDATA_O, x);
    @(posedge CLOCK_I);
  endtask
  task automatic settle;
    repeat (3) @(posedge CLOCK_I);
    @(negedge CLOCK_I);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    CLOCK_I = 1'b0;
    forever #20 CLOCK_I = ~CLOCK_I;
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    #100000;
    n_errors++;
    complete_run;
  end
  initial begin
    RESET_N_I = 1'b0;
    REG_ADDR_I = 4'h0;
    REG_WDATA_I = 32'h0;
    REG_WR_I = 1'b0;
    REG_RD_I = 1'b0;
    bset = 7'h00;
    repeat (3) @(posedge CLOCK_I);
    RESET_N_I <= 1'b1;
    @(posedge CLOCK_I);
    rd(`PCOC_ADDR_RATIO0, `PCOC_RATIO_RST);
    for (int m = 0; m < 4; m++) begin
      wr(m[3:0], RB + (m << 16));
    end
    wr(`PCOC_ADDR_MODAL, 32'h000f_aab0);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      wr(`PCOC_ADDR_GLOBAL, {23'h0, r[8:6], 6'h0});
      bset <= {2'b00, r[5], 4'b1001};
      settle;
      chk(MAIN_CLK_OE_N_O, r[4]);
      chk(AUX_OE_N_O, r[3]);
      chk(AUTO_RATIO_MOD_EN_O, r[2]);
      if (!r[3]) chk(AUX_O, r[1]);
      chk(EFF_RATIO_O, r[0] ? RB >> 1 : RB);
      @(posedge CLOCK_I);
    end
    wr(`PCOC_ADDR_GLOBAL, 32'h0c0);
    for (int m = 0; m < 4; m++) begin
      bset <= {m[1:0], 5'b10111};
      settle;
      e = (RB + (m << 16)) >> (m + 1);
      chk(EFF_RATIO_O, e);
      chk(RATIO_INT_O, e[31:12]);
      chk(AUX_O, m == 1 || m == 2);
      chk(AUTO_RATIO_MOD_EN_O, m != 2);
      @(posedge CLOCK_I);
    end
    wr(`PCOC_ADDR_GLOBAL, 32'h0e0);
    settle;
    chk({RATIO_FORMAT_O, RATIO_INT_O}, {1'b1, 8'h00, e[31:20]});
    @(posedge CLOCK_I);
    for (int i = 0; i < 8; i++) begin
      wr(`PCOC_ADDR_GLOBAL, (i << 9) | ((i & 3) << 2) | (i & 1));
      bset <= {i[1:0], 5'b00111};
      settle;
      chk(MIN_LOOP_BW_HZ_O, 1 << i);
      chk(REF_DIVIDE_O, (i & 3) == 3 ? 0 : 4 >> (i & 3));
      chk(SKIP_TOLERANCE_EN_O, i & 1);
      @(posedge CLOCK_I);
    end
    wr(`PCOC_ADDR_GLOBAL, 32'h100);
    bset <= 7'b1101010;
    settle;
    chk({MAIN_CLK_O, AUX_O, AUX_OE_N_O}, 3'b010);
    @(posedge CLOCK_I);
    wr(`PCOC_ADDR_GLOBAL, 32'h112);
    settle;
    chk({MAIN_CLK_O, AUX_O, AUX_OE_N_O}, 3'b100);
    @(posedge CLOCK_I);
    bset <= 7'b1101011;
    settle;
    chk({AUX_O, AUX_OE_N_O}, 2'b01);
    @(posedge CLOCK_I);
    bset <= 7'b0001011;
    settle;
    chk({AUX_O, AUX_OE_N_O}, 2'b10);
    @(posedge CLOCK_I);
    rd(`PCOC_ADDR_RATIO2, RB + 32'h2_0000);
    rd(`PCOC_ADDR_MODAL, 32'h000f_aab0);
    rd(4'hf, 32'h0);
    // A second reset in mid-run must disable the pins and return stored ratios to their reset value.
    RESET_N_I <= 1'b0;
    @(negedge CLOCK_I);
    chk({MAIN_CLK_OE_N_O, AUX_OE_N_O, MAIN_CLK_O}, 3'b110);
    chk(EFF_RATIO_O, 32'h0);
    @(posedge CLOCK_I);
    RESET_N_I <= 1'b1;
    @(posedge CLOCK_I);
    rd(`PCOC_ADDR_RATIO2, `PCOC_RATIO_RST);
    complete_run;
  end
endmodule // tb
